/* File: design/pcs_pkg.sv */
// Purpose: constants for the power control and serial buffer block
// Assumes: 32-bit AXI4-Lite register bus, 25 MHz clock
// Notes: register indices times four give byte addresses
`default_nettype none
package pcs_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned IDX_W  = 10;
	localparam logic [IDX_W-1:0] IDX_SERCTL = 10'h098;
	localparam logic [IDX_W-1:0] IDX_SERBUF = 10'h099;
	localparam logic [IDX_W-1:0] IDX_PWRCTL = 10'h087;
	localparam int unsigned BIT_DOUBLER = 7;
	localparam int unsigned BIT_VIEWSEL = 6;
	localparam int unsigned BIT_RSVD    = 5;
	localparam int unsigned BIT_SUPPLY  = 4;
	localparam int unsigned BIT_UF1     = 3;
	localparam int unsigned BIT_UF0     = 2;
	localparam int unsigned BIT_PWRDN   = 1;
	localparam int unsigned BIT_IDLE    = 0;
	localparam int unsigned BIT_MODE_LO = 7;
	localparam int unsigned BIT_MODE_HI = 6;
	localparam logic [7:0] SERBUF_RESET = 8'h00;
	localparam logic [6:0] SERCTL_RESET = 7'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [IDX_W-1:0] reg_index(
		input logic [ADDR_W-1:0] addr);
		return addr[ADDR_W-1:2];
	endfunction

	function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
		return idx == IDX_SERCTL || idx == IDX_SERBUF || idx == IDX_PWRCTL;
	endfunction
endpackage
`default_nettype wire

/* File: design/pcs_lp_if.sv */
// Purpose: carrier between register file and low-power control
// Assumes: single clock domain
// Notes: write strobe is one cycle
`default_nettype none
interface pcs_lp_if;
	logic wr_en;
	logic wr_idle;
	logic wr_pwrdn;
	logic wake;
	logic idle;
	logic pwrdn;
	logic core_clk_en;
	logic periph_clk_en;
	modport regs (output wr_en, output wr_idle, output wr_pwrdn, output wake,
		input idle, input pwrdn, input core_clk_en, input periph_clk_en);
	modport lp (input wr_en, input wr_idle, input wr_pwrdn, input wake,
		output idle, output pwrdn, output core_clk_en,
		output periph_clk_en);
endinterface
`default_nettype wire

/* File: design/pcs_lowpower.sv */
// Purpose: idle and power-down bits with clock enables
// Assumes: interrupt wake is a level or pulse
// Notes: a wake in the cycle of an idle write leaves idle clear
`default_nettype none
module pcs_lowpower (
	input  wire logic clock,
	input  wire logic rst,
	pcs_lp_if.lp      bus
);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bus.pwrdn <= 1'b0;
		end else if (bus.wr_en && bus.wr_pwrdn) begin
			bus.pwrdn <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bus.idle <= 1'b0;
		end else if (bus.wake) begin
			bus.idle <= 1'b0;
		end else if (bus.wr_en && bus.wr_idle) begin
			bus.idle <= 1'b1;
		end
	end

	// enables follow the bits one cycle later
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bus.core_clk_en   <= 1'b1;
			bus.periph_clk_en <= 1'b1;
		end else begin
			bus.core_clk_en   <= !bus.idle && !bus.pwrdn;
			bus.periph_clk_en <= !bus.pwrdn;
		end
	end

	a_powerdown_held: assert property (@(posedge clock) disable iff (rst)
		bus.pwrdn |=> bus.pwrdn)
		else $error("power-down left without reset");
	a_idle_wake: assert property (@(posedge clock) disable iff (rst)
		bus.wake |=> !bus.idle)
		else $error("idle not cleared by interrupt");
	a_clock_gating: assert property (@(posedge clock) disable iff (rst)
		bus.idle && !bus.pwrdn |=> !bus.core_clk_en && bus.periph_clk_en)
		else $error("idle clock gating wrong");
endmodule // pcs_lowpower
`default_nettype wire

/* File: design/pcs_frame_err.sv */
// Purpose: sticky framing error flag
// Assumes: stop_bad is a one-cycle pulse from the receiver
// Notes: set wins over a clear in the same cycle
`default_nettype none
module pcs_frame_err (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic stop_bad,
	input  wire logic sw_clear,
	output var  logic flag
);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flag <= 1'b0;
		end else if (stop_bad) begin
			flag <= 1'b1;
		end else if (sw_clear) begin
			flag <= 1'b0;
		end
	end

	a_frame_sticky: assert property (@(posedge clock) disable iff (rst)
		flag && !sw_clear |=> flag)
		else $error("frame error dropped without software clear");
endmodule // pcs_frame_err
`default_nettype wire

/* File: design/pcs_power_serial.sv */
// Purpose: power control, serial control view and serial data buffer
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes: power_on_reset also resets everything rst resets
//
// Decided for this implementation: register access over AXI4-Lite.
`default_nettype none
module pcs_power_serial (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        power_on_reset,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_load,
	input  wire logic        stop_bit_bad,
	input  wire logic        irq_request,
	output var  logic [7:0]  tx_byte,
	output var  logic        tx_load,
	output var  logic        baud_rate_double,
	output var  logic        core_clock_enable,
	output var  logic        periph_clock_enable
);
	logic        any_rst;
	logic        aw_got;
	logic        w_got;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic        w_strb0;
	logic        do_write;
	logic        do_read;
	logic [9:0]  wr_idx;
	logic [9:0]  rd_idx;
	logic        wr_serctl;
	logic        wr_serbuf;
	logic        wr_pwrctl;
	logic [7:0]  serbuf_rx;
	logic [6:0]  serctl_low;
	logic        mode_low;
	logic        supply_up_flag;
	logic        baud_doubler;
	logic        frame_error_view_select;
	logic        user_flag_one;
	logic        user_flag_zero;
	logic        frame_error_flag;
	logic        frame_err_clear;
	logic [7:0]  pwrctl_view;
	logic [7:0]  serctl_view;
	logic [31:0] next_rdata;
	logic [1:0]  serial_mode;

	pcs_lp_if lp_bus ();

	assign any_rst  = rst | power_on_reset;
	assign do_write = aw_got && w_got && !s_axi_bvalid;
	assign do_read  = s_axi_arvalid && s_axi_arready;
	assign wr_idx   = pcs_pkg::reg_index(aw_addr);
	assign rd_idx   = pcs_pkg::reg_index(s_axi_araddr);
	assign wr_serctl = do_write && w_strb0 && wr_idx == pcs_pkg::IDX_SERCTL;
	assign wr_serbuf = do_write && w_strb0 && wr_idx == pcs_pkg::IDX_SERBUF;
	assign wr_pwrctl = do_write && w_strb0 && wr_idx == pcs_pkg::IDX_PWRCTL;
	assign serial_mode = {mode_low, serctl_low[pcs_pkg::BIT_MODE_HI]};

	// write address and data are taken in either order
	always_ff @(posedge clock or posedge any_rst) begin
		if (any_rst) begin
			aw_got        <= 1'b0;
			aw_addr       <= 12'h000;
			s_axi_awready <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got  <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_got <= 1'b0;
			end
			s_axi_awready <= !aw_got && !s_axi_bvalid && !do_write &&
				!(s_axi_awvalid && s_axi_awready);
		end
	end

	always_ff @(posedge clock or posedge any_rst) begin
		if (any_rst) begin
			w_got        <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb0      <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_got   <= 1'b1;
				w_data  <= s_axi_wdata;
				w_strb0 <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_got <= 1'b0;
			end
			s_axi_wready <= !w_got && !s_axi_bvalid && !do_write &&
				!(s_axi_wvalid && s_axi_wready);
		end
	end

	always_ff @(posedge clock or posedge any_rst) begin
		if (any_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= pcs_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= pcs_pkg::is_mapped(wr_idx) ?
				pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge clock or posedge any_rst) begin
		if (any_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= pcs_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !do_read;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= pcs_pkg::is_mapped(rd_idx) ?
					pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// reserved bit reads as zero
	always_comb begin
		pwrctl_view = 8'h00;
		pwrctl_view[pcs_pkg::BIT_DOUBLER] = baud_doubler;
		pwrctl_view[pcs_pkg::BIT_VIEWSEL] = frame_error_view_select;
		pwrctl_view[pcs_pkg::BIT_SUPPLY]  = supply_up_flag;
		pwrctl_view[pcs_pkg::BIT_UF1]     = user_flag_one;
		pwrctl_view[pcs_pkg::BIT_UF0]     = user_flag_zero;
		pwrctl_view[pcs_pkg::BIT_PWRDN]   = lp_bus.pwrdn;
		pwrctl_view[pcs_pkg::BIT_IDLE]    = lp_bus.idle;
	end

	always_comb begin
		serctl_view = {frame_error_view_select ? frame_error_flag : mode_low,
			serctl_low};
		case (rd_idx)
			pcs_pkg::IDX_SERCTL: next_rdata = {24'h000000, serctl_view};
			pcs_pkg::IDX_SERBUF: next_rdata = {24'h000000, serbuf_rx};
			pcs_pkg::IDX_PWRCTL: next_rdata = {24'h000000, pwrctl_view};
			default:             next_rdata = 32'h0000_0000;
		endcase
	end

	// serial data buffer: write goes out, received byte reads back
	always_ff @(posedge clock or posedge any_rst) begin
		if (any_rst) begin
			tx_byte   <= pcs_pkg::SERBUF_RESET;
			tx_load   <= 1'b0;
			serbuf_rx <= pcs_pkg::SERBUF_RESET;
		end else begin
			tx_load <= wr_serbuf;
			if (wr_serbuf) begin
				tx_byte <= w_data[7:0];
			end
			if (rx_load) begin
				serbuf_rx <= rx_byte;
			end
		end
	end

	// serial control: bit 7 is mode bit or frame error by view select
	always_ff @(posedge clock or posedge any_rst) begin
		if (any_rst) begin
			serctl_low <= pcs_pkg::SERCTL_RESET;
			mode_low   <= 1'b0;
		end else if (wr_serctl) begin
			serctl_low <= w_data[6:0];
			if (!frame_error_view_select) begin
				mode_low <= w_data[pcs_pkg::BIT_MODE_LO];
			end
		end
	end

	assign frame_err_clear = wr_serctl && frame_error_view_select &&
		!w_data[pcs_pkg::BIT_MODE_LO];

	pcs_frame_err u_frame_err (
		.clock    (clock),
		.rst      (any_rst),
		.stop_bad (stop_bit_bad),
		.sw_clear (frame_err_clear),
		.flag     (frame_error_flag)
	);

	// supply-up flag survives rst, set by power-on reset, loaded from bit 4 by a power control write
	always_ff @(posedge clock or posedge power_on_reset) begin
		if (power_on_reset) begin
			supply_up_flag <= 1'b1;
		end else if (wr_pwrctl) begin
			supply_up_flag <= w_data[pcs_pkg::BIT_SUPPLY];
		end
	end

	// bit 5 has no storage, so a stray one is dropped
	always_ff @(posedge clock or posedge any_rst) begin
		if (any_rst) begin
			baud_doubler            <= 1'b0;
			frame_error_view_select <= 1'b0;
			user_flag_one           <= 1'b0;
			user_flag_zero          <= 1'b0;
		end else if (wr_pwrctl) begin
			baud_doubler            <= w_data[pcs_pkg::BIT_DOUBLER];
			frame_error_view_select <= w_data[pcs_pkg::BIT_VIEWSEL];
			user_flag_one           <= w_data[pcs_pkg::BIT_UF1];
			user_flag_zero          <= w_data[pcs_pkg::BIT_UF0];
		end
	end

	always_ff @(posedge clock or posedge any_rst) begin
		if (any_rst) begin
			baud_rate_double <= 1'b0;
		end else begin
			baud_rate_double <= baud_doubler && serial_mode != 2'h0;
		end
	end

	assign lp_bus.wr_en    = wr_pwrctl;
	assign lp_bus.wr_idle  = w_data[pcs_pkg::BIT_IDLE];
	assign lp_bus.wr_pwrdn = w_data[pcs_pkg::BIT_PWRDN];
	assign lp_bus.wake    = irq_request;

	pcs_lowpower u_lowpower (
		.clock (clock),
		.rst   (any_rst),
		.bus   (lp_bus.lp)
	);

	assign core_clock_enable   = lp_bus.core_clk_en;
	assign periph_clock_enable = lp_bus.periph_clk_en;

	a_buffer_write: assert property (@(posedge clock) disable iff (any_rst)
		wr_serbuf |=> tx_load && tx_byte == $past(w_data[7:0]))
		else $error("buffer write not passed to transmitter");
	a_baud_double: assert property (@(posedge clock) disable iff (any_rst)
		baud_doubler && serial_mode == 2'h0 |=> !baud_rate_double)
		else $error("baud doubled in mode 0");
	a_control_view: assert property (@(posedge clock) disable iff (any_rst)
		do_read && rd_idx == pcs_pkg::IDX_SERCTL |=>
		s_axi_rdata[7] == $past(frame_error_view_select ?
		frame_error_flag : mode_low))
		else $error("control bit 7 view wrong");
	a_reserved_zero: assert property (@(posedge clock) disable iff (any_rst)
		do_read && rd_idx == pcs_pkg::IDX_PWRCTL |=>
		!s_axi_rdata[pcs_pkg::BIT_RSVD])
		else $error("reserved bit read as one");
	a_supply_keep: assert property (@(posedge clock)
		disable iff (power_on_reset)
		!wr_pwrctl |=> supply_up_flag == $past(supply_up_flag))
		else $error("supply-up flag changed without power-on");
	a_supply_write: assert property (@(posedge clock)
		disable iff (power_on_reset)
		wr_pwrctl |=> supply_up_flag ==
		$past(w_data[pcs_pkg::BIT_SUPPLY]))
		else $error("supply-up flag write lost");
	a_user_flags: assert property (@(posedge clock) disable iff (any_rst)
		!wr_pwrctl |=> $stable({user_flag_one, user_flag_zero}))
		else $error("user flags changed by hardware");
	a_powerdown_enter: assert property (@(posedge clock)
		disable iff (any_rst)
		wr_pwrctl && w_data[pcs_pkg::BIT_PWRDN] |=> lp_bus.pwrdn ##1
		!periph_clock_enable)
		else $error("power-down not entered");
	a_idle_enter: assert property (@(posedge clock) disable iff (any_rst)
		wr_pwrctl && w_data[pcs_pkg::BIT_IDLE] && !irq_request |=>
		lp_bus.idle ##1 !core_clock_enable)
		else $error("idle not entered");
	a_write_answer: assert property (@(posedge clock) disable iff (any_rst)
		do_write |=> s_axi_bvalid)
		else $error("write response missing");

	c_idle_wake: cover property (@(posedge clock) disable iff (any_rst)
		lp_bus.idle ##1 irq_request ##1 !lp_bus.idle);
	c_frame_view: cover property (@(posedge clock) disable iff (any_rst)
		frame_error_flag && frame_error_view_select && do_read);
	c_power_down: cover property (@(posedge clock) disable iff (any_rst)
		lp_bus.pwrdn && !periph_clock_enable);
	c_baud_on: cover property (@(posedge clock) disable iff (any_rst)
		baud_rate_double);
endmodule // pcs_power_serial
`default_nettype wire

/* File: dv/test_power_control_and_serial_buffer.sv */
// Purpose: self-checking bench for the power control and serial buffer block
// Assumes: AXI4-Lite master driven here, 25 MHz clock, no partner model
// Notes: register byte address is the package index times four
`default_nettype none
module test_power_control_and_serial_buffer;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [11:0] A_PWR = {pcs_pkg::IDX_PWRCTL, 2'b00};
	localparam logic [11:0] A_CTL = {pcs_pkg::IDX_SERCTL, 2'b00};
	localparam logic [11:0] A_BUF = {pcs_pkg::IDX_SERBUF, 2'b00};
	localparam logic [11:0] A_NONE = 12'h000;

	logic        clock          = 1'b0;
	logic        rst            = 1'b1;
	logic        power_on_reset = 1'b1;
	logic [11:0] s_axi_awaddr   = 12'h000;
	logic        s_axi_awvalid  = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata    = 32'h00000000;
	logic [3:0]  s_axi_wstrb    = 4'h0;
	logic        s_axi_wvalid   = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready   = 1'b0;
	logic [11:0] s_axi_araddr   = 12'h000;
	logic        s_axi_arvalid  = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready   = 1'b0;
	logic [7:0]  rx_byte        = 8'h00;
	logic        rx_load        = 1'b0;
	logic        stop_bit_bad   = 1'b0;
	logic        irq_request    = 1'b0;
	logic [7:0]  tx_byte;
	logic        tx_load;
	logic        baud_rate_double;
	logic        core_clock_enable;
	logic        periph_clock_enable;
	int          n_fail         = 0;
	int          n_tests        = 0;
	int          n_load         = 0;
	int          base;
	logic [31:0] rd_data;
	logic [1:0]  resp;

	pcs_power_serial u_dut (
		.clock(clock), .rst(rst), .power_on_reset(power_on_reset),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .rx_byte(rx_byte), .rx_load(rx_load),
		.stop_bit_bad(stop_bit_bad), .irq_request(irq_request),
		.tx_byte(tx_byte), .tx_load(tx_load),
		.baud_rate_double(baud_rate_double),
		.core_clock_enable(core_clock_enable),
		.periph_clock_enable(periph_clock_enable)
	);

	initial begin
		forever #20 clock = ~clock;
	end

	// count transmit load pulses, one per buffer write
	always @(posedge clock) begin
		if (tx_load === 1'b1)
			n_load <= n_load + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		int   n;
		aw_ok = 1'b0;
		w_ok  = 1'b0;
		n     = 0;
		@(posedge clock);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h000000, d};
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!(aw_ok && w_ok) && n < 100) begin
			@(posedge clock);
			n++;
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1 && n < 100) begin
			@(posedge clock);
			n++;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 100)
			check(32'h00000001, 32'h00000000);
	endtask

	task automatic axi_rd(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (s_axi_arready !== 1'b1 && n < 100);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1 && n < 100) begin
			@(posedge clock);
			n++;
		end
		rd_data = s_axi_rdata;
		resp    = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 100)
			check(32'h00000001, 32'h00000000);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		axi_wr(a, d, 4'hF, resp);
		check(resp, pcs_pkg::RESP_OKAY);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		axi_rd(a);
		check(resp, pcs_pkg::RESP_OKAY);
		check(rd_data, {24'h000000, e});
	endtask

	task automatic pulse_reset(input logic por);
		@(posedge clock);
		if (por)
			power_on_reset <= 1'b1;
		else
			rst <= 1'b1;
		cyc(2);
		power_on_reset <= 1'b0;
		rst <= 1'b0;
		cyc(2);
	endtask

	task automatic pulse_irq();
		@(posedge clock);
		irq_request <= 1'b1;
		@(posedge clock);
		irq_request <= 1'b0;
		cyc(2);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		cyc(20000);
		n_fail++;
		results();
	end

	initial begin
		cyc(12);
		rst <= 1'b0;
		power_on_reset <= 1'b0;
		cyc(2);
		rd_chk(A_PWR, 8'h10);
		rd_chk(A_BUF, pcs_pkg::SERBUF_RESET);
		check(tx_byte, 8'h00);
		check(core_clock_enable, 1'b1);
		$display("test reset_values done");
		wr(A_PWR, 8'h0C);
		rd_chk(A_PWR, 8'h0C);
		pulse_reset(1'b0);
		axi_rd(A_PWR);
		check(rd_data[4], 1'b0);
		wr(A_PWR, 8'h18);
		rd_chk(A_PWR, 8'h18);
		pulse_reset(1'b0);
		axi_rd(A_PWR);
		check(rd_data[4], 1'b1);
		wr(A_PWR, 8'h00);
		pulse_reset(1'b1);
		axi_rd(A_PWR);
		check(rd_data[4], 1'b1);
		$display("test supply_and_user_flags done");
		wr(A_PWR, 8'h01);
		cyc(2);
		check(core_clock_enable, 1'b0);
		check(periph_clock_enable, 1'b1);
		wr(A_PWR, 8'h04);
		rd_chk(A_PWR, 8'h05);
		pulse_irq();
		rd_chk(A_PWR, 8'h04);
		check(core_clock_enable, 1'b1);
		wr(A_PWR, 8'h01);
		pulse_reset(1'b0);
		axi_rd(A_PWR);
		check(rd_data[1:0], 2'h0);
		$display("test idle done");
		wr(A_PWR, 8'h02);
		cyc(2);
		check(periph_clock_enable, 1'b0);
		check(core_clock_enable, 1'b0);
		pulse_irq();
		axi_rd(A_PWR);
		check(rd_data[1], 1'b1);
		pulse_reset(1'b0);
		axi_rd(A_PWR);
		check(rd_data[1], 1'b0);
		check(periph_clock_enable, 1'b1);
		$display("test power_down done");
		for (int k = 0; k < 8; k++) begin
			wr(A_PWR, {k[2], 7'h00});
			wr(A_CTL, {k[1:0], 6'h00});
			cyc(2);
			check(baud_rate_double, k[2] && k[1:0] != 2'h0);
		end
		$display("test baud_doubler done");
		wr(A_PWR, 8'h00);
		wr(A_CTL, 8'h80);
		rd_chk(A_CTL, 8'h80);
		wr(A_PWR, 8'h40);
		rd_chk(A_CTL, 8'h00);
		@(posedge clock);
		stop_bit_bad <= 1'b1;
		@(posedge clock);
		stop_bit_bad <= 1'b0;
		cyc(4);
		rd_chk(A_CTL, 8'h80);
		wr(A_CTL, 8'h80);
		rd_chk(A_CTL, 8'h80);
		wr(A_CTL, 8'h00);
		rd_chk(A_CTL, 8'h00);
		wr(A_PWR, 8'h00);
		rd_chk(A_CTL, 8'h80);
		$display("test frame_error_view done");
		base = n_load;
		wr(A_BUF, 8'hA5);
		cyc(3);
		check(tx_byte, 8'hA5);
		check(n_load - base, 1);
		@(posedge clock);
		rx_byte <= 8'h3C;
		rx_load <= 1'b1;
		@(posedge clock);
		rx_load <= 1'b0;
		rx_byte <= 8'hC3;
		rd_chk(A_BUF, 8'h3C);
		$display("test serial_buffer done");
		axi_wr(A_NONE, 8'hFF, 4'hF, resp);
		check(resp, pcs_pkg::RESP_SLVERR);
		axi_rd(A_NONE);
		check(resp, pcs_pkg::RESP_SLVERR);
		check(rd_data, 32'h00000000);
		axi_wr(A_PWR, 8'h0C, 4'hE, resp);
		check(resp, pcs_pkg::RESP_OKAY);
		rd_chk(A_PWR, 8'h00);
		$display("test bus_errors done");
		results();
	end
endmodule // test_power_control_and_serial_buffer
`default_nettype wire
